// ===== hdl/spc_pkg.sv
/*
 * Shared constants and types for the power switch trip controller:
 * sample scaling, integrator figures, timing counts and the switch states.
 * Assumes a 40 MHz ref_clk on both ends and a 12-bit unsigned current
 * sample in which RATED_CNT counts equal the rated load current.
 */
package spc_pkg;

    // Clock rate of both ends
    localparam int CLK_HZ = 40_000_000;

    // Trip override is looked at once per this period
    localparam int OVR_PERIOD_MS = 20;
    localparam int OVR_PERIOD_CYC = (CLK_HZ / 1000) * OVR_PERIOD_MS;

    // Host waits this long after a command edge before judging the flags
    localparam int SETTLE_US = 650;
    localparam int SETTLE_CYC = (CLK_HZ / 1_000_000) * SETTLE_US;

    // Current sample scaling
    localparam int CUR_W = 12;
    localparam int SQ_W = 2 * CUR_W;
    localparam logic [11:0] RATED_CNT = 12'h100;

    // Integrator: leaky accumulator, steady value = square << LEAK_SHIFT
    localparam int ACC_W = 34;
    localparam int LEAK_SHIFT = 8;
    localparam int NO_TRIP_PCT = 110;
    localparam int TRIP_PCT = 120;
    localparam int TRIP_CUR = (256 * TRIP_PCT) / 100;
    localparam logic [33:0] ACC_TRIP =
        34'(TRIP_CUR * TRIP_CUR) << LEAK_SHIFT;

    // Instant trip at 800 % of rated, inside the 700..900 % window
    localparam int INST_PCT = 800;
    localparam logic [11:0] INST_CNT = 12'((256 * INST_PCT) / 100);

    // Load flag threshold at 10 %, between the 5 % and 15 % limits
    localparam int IDLE_PCT = 10;
    localparam logic [11:0] IDLE_CNT = 12'((256 * IDLE_PCT) / 100);

    // Watchdog timeout in rising edges of its own oscillator
    localparam int WDT_W = 16;
    localparam logic [15:0] WDT_TIMEOUT = 16'h03e8;

    // Values after reset
    localparam logic RST_LOAD_FLAG = 1'b1;
    localparam logic RST_SWITCH_FLAG = 1'b0;

    typedef enum logic [1:0] {
        SPC_OFF,
        SPC_ON,
        SPC_TRIP
    } spc_state_t;

endpackage

// ===== hdl/spc_link_if.sv
/*
 * Control and status link between the host controller and the switch.
 * Assumes both ends run from the same reset and clock family; the device
 * still synchronises every link input because the link crosses an isolator.
 */
`timescale 1ns/10ps

interface spc_link_if;
    logic on_cmd;
    logic trip_override;
    logic load_flag;
    logic switch_flag;

    // Device end reads the commands and drives the status flags
    modport dev (
        input on_cmd,
        input trip_override,
        output load_flag,
        output switch_flag
    );

    // Host end drives the commands and reads the status flags
    modport host (
        output on_cmd,
        output trip_override,
        input load_flag,
        input switch_flag
    );
endinterface

// ===== hdl/spc_dev.sv
/*
 * Device end: overcurrent protection of a solid state DC power switch.
 * Squares each current sample into a leaky integrator, trips on its
 * threshold or instantly on gross overload, honours the trip override,
 * and runs a watchdog off a separate oscillator.
 * Assumes cur_sample/cur_valid come from an ADC on ref_clk, and that
 * rst is asserted whenever the logic supply is applied.
 */
`timescale 1ns/10ps

// Overview of operation
// - Square samples, integrate, trip over threshold
// - Integrator memory makes repeat overloads trip sooner
// - Watchdog on own oscillator resets the controller
// - On command is a level, followed after reset
// - Override blocks trips and restores tripped switch
// - Override sampled once every 20 ms
// - Host keeps override free of contact bounce
// - Command low clears trip, high turns on
// - Persisting overload trips again after re-enable
// - Supply reset then on if command high
// - Load flag high at low current, low loaded
// - Switch flag follows conducting state
// - Host compares command with both flags
// - Host accepts three normal states plus tripped
// - Host flags remaining combinations as faults
// - No trip at 110 % rated current
// - Instant trip near 800 % rated current
module spc_dev #(
    parameter int OVR_PERIOD = spc_pkg::OVR_PERIOD_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    spc_link_if.dev link,
    input wire logic [11:0] cur_sample,
    input wire logic cur_valid,
    input wire logic wdt_osc,
    input wire logic fw_kick,
    output logic switch_gate,
    output logic wdt_fired
);

    // Link input and watchdog oscillator synchronisers
    logic cmd_s1_q, cmd_s2_q;
    logic ovr_s1_q, ovr_s2_q;
    logic osc_s1_q, osc_s2_q, osc_s3_q;

    // Override sampling
    logic [19:0] per_cnt_q, per_cnt_d;
    logic ovr_q, ovr_d;

    // Watchdog
    logic [15:0] wdt_cnt_q, wdt_cnt_d;
    logic ireset_q, ireset_d;

    // Integrator
    logic [33:0] acc_q, acc_d;
    logic [23:0] sq;
    logic over_heat, over_inst;

    // Switch state and outputs
    spc_pkg::spc_state_t st_q, st_d;
    logic gate_q, gate_d;
    logic load_q, load_d;
    logic sw_flag_q;

    // Two flops on every signal that crosses the isolator or the oscillator
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmd_s1_q <= 1'b0;
            cmd_s2_q <= 1'b0;
            ovr_s1_q <= 1'b0;
            ovr_s2_q <= 1'b0;
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            cmd_s1_q <= link.on_cmd;
            cmd_s2_q <= cmd_s1_q;
            // An unknown or open override level is taken as deasserted
            ovr_s1_q <= (link.trip_override === 1'b1);
            ovr_s2_q <= ovr_s1_q;
            osc_s1_q <= wdt_osc;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    // Override is latched only at period ends, so short glitches between
    // samples are ignored but bounce across a sample still shows through
    always_comb begin
        per_cnt_d = per_cnt_q + 20'h00001;
        ovr_d = ovr_q;
        if (per_cnt_q == 20'(OVR_PERIOD - 1)) begin
            per_cnt_d = 20'h00000;
            ovr_d = ovr_s2_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            per_cnt_q <= 20'h00000;
            ovr_q <= 1'b0;
        end else begin
            per_cnt_q <= per_cnt_d;
            ovr_q <= ovr_d;
        end
    end

    // Watchdog counts oscillator edges; firmware kicks restart it.
    // Limitation: with one clock a dead ref_clk also stops this counter.
    always_comb begin
        wdt_cnt_d = wdt_cnt_q;
        ireset_d = 1'b0;
        if (fw_kick || ireset_q) begin
            wdt_cnt_d = 16'h0000;
        end else if (osc_s2_q && !osc_s3_q) begin
            if (wdt_cnt_q == spc_pkg::WDT_TIMEOUT - 16'h0001) begin
                wdt_cnt_d = 16'h0000;
                ireset_d = 1'b1;
            end else begin
                wdt_cnt_d = wdt_cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wdt_cnt_q <= 16'h0000;
            ireset_q <= 1'b0;
        end else begin
            wdt_cnt_q <= wdt_cnt_d;
            ireset_q <= ireset_d;
        end
    end

    // Squared current into a leaky sum: the sum decays by 1/256 per
    // sample, so it settles at square*256 and keeps history between
    // overloads, which shortens the next trip
    assign sq = 24'(cur_sample) * 24'(cur_sample);
    assign over_heat = (acc_q >= spc_pkg::ACC_TRIP);
    assign over_inst = cur_valid && (cur_sample > spc_pkg::INST_CNT);

    always_comb begin
        acc_d = acc_q;
        if (ireset_q) begin
            acc_d = '0;
        end else if (cur_valid) begin
            acc_d = acc_q - (acc_q >> spc_pkg::LEAK_SHIFT)
                + {10'h000, sq};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    // Switch state follows the command level; trips latch until released
    always_comb begin
        st_d = st_q;
        case (st_q)
            spc_pkg::SPC_OFF: begin
                if (cmd_s2_q) begin
                    st_d = spc_pkg::SPC_ON;
                end
            end
            spc_pkg::SPC_ON: begin
                if (!cmd_s2_q) begin
                    st_d = spc_pkg::SPC_OFF;
                end else if (!ovr_q && (over_heat || over_inst)) begin
                    st_d = spc_pkg::SPC_TRIP;
                end
            end
            spc_pkg::SPC_TRIP: begin
                if (!cmd_s2_q) begin
                    st_d = spc_pkg::SPC_OFF;
                end else if (ovr_q) begin
                    st_d = spc_pkg::SPC_ON;
                end
            end
            default: begin
                st_d = spc_pkg::SPC_OFF;
            end
        endcase
        // Controller reset forgets the trip and takes the command level
        if (ireset_q) begin
            st_d = cmd_s2_q ? spc_pkg::SPC_ON : spc_pkg::SPC_OFF;
        end
    end

    // Gate and switch flag are registered from the next state so both agree in a cycle; load flag follows the samples
    always_comb begin
        gate_d = (st_d == spc_pkg::SPC_ON);
        load_d = load_q;
        if (cur_valid) begin
            load_d = (cur_sample <= spc_pkg::IDLE_CNT);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= spc_pkg::SPC_OFF;
            gate_q <= 1'b0;
            sw_flag_q <= spc_pkg::RST_SWITCH_FLAG;
            load_q <= spc_pkg::RST_LOAD_FLAG;
            wdt_fired <= 1'b0;
        end else begin
            st_q <= st_d;
            gate_q <= gate_d;
            sw_flag_q <= gate_d;
            load_q <= load_d;
            wdt_fired <= ireset_d;
        end
    end

    assign switch_gate = gate_q;
    assign link.switch_flag = sw_flag_q;
    assign link.load_flag = load_q;

endmodule

// ===== hdl/spc_host.sv
/*
 * Host end: drives the on command and trip override, and classifies
 * the command against the two status flags into normal, tripped or fault.
 * Assumes on_req/override_req come from logic on ref_clk and that the
 * device answers within SETTLE_CYC cycles of a command change.
 */
`timescale 1ns/10ps

module spc_host #(
    parameter int SETTLE = spc_pkg::SETTLE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    spc_link_if.host link,
    input wire logic on_req,
    input wire logic override_req,
    output logic st_settled,
    output logic st_off_ok,
    output logic st_on_load,
    output logic st_on_idle,
    output logic st_tripped,
    output logic st_fault
);

    logic cmd_q, ovr_q;
    logic lf_s1_q, lf_s2_q, sf_s1_q, sf_s2_q;
    logic [14:0] settle_q, settle_d;
    logic done;
    logic [2:0] combo;
    logic off_d, load_d, idle_d, trip_d, fault_d;

    // Override is a clean register level, never a raw contact
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmd_q <= 1'b0;
            ovr_q <= 1'b0;
            lf_s1_q <= 1'b0;
            lf_s2_q <= 1'b0;
            sf_s1_q <= 1'b0;
            sf_s2_q <= 1'b0;
        end else begin
            cmd_q <= on_req;
            ovr_q <= override_req;
            lf_s1_q <= link.load_flag;
            lf_s2_q <= lf_s1_q;
            sf_s1_q <= link.switch_flag;
            sf_s2_q <= sf_s1_q;
        end
    end

    // Flags lag the command, so judging too early would raise false faults.
    // A switch flag change restarts the wait too: the load flag trails a
    // trip by a sample, and that gap would otherwise read as a fault
    assign done = (settle_q == 15'(SETTLE));
    always_comb begin
        settle_d = done ? settle_q : settle_q + 15'h0001;
        if (on_req != cmd_q || sf_s1_q != sf_s2_q) begin
            settle_d = 15'h0000;
        end
    end

    // Decode command, load flag, switch flag
    assign combo = {cmd_q, lf_s2_q, sf_s2_q};
    always_comb begin
        off_d = 1'b0;
        load_d = 1'b0;
        idle_d = 1'b0;
        trip_d = 1'b0;
        fault_d = 1'b0;
        if (done) begin
            case (combo)
                3'h2: off_d = 1'b1;
                3'h5: load_d = 1'b1;
                3'h7: idle_d = 1'b1;
                3'h6: trip_d = 1'b1;
                default: fault_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            settle_q <= 15'h0000;
            st_settled <= 1'b0;
            st_off_ok <= 1'b0;
            st_on_load <= 1'b0;
            st_on_idle <= 1'b0;
            st_tripped <= 1'b0;
            st_fault <= 1'b0;
        end else begin
            settle_q <= settle_d;
            st_settled <= done;
            st_off_ok <= off_d;
            st_on_load <= load_d;
            st_on_idle <= idle_d;
            st_tripped <= trip_d;
            st_fault <= fault_d;
        end
    end

    assign link.on_cmd = cmd_q;
    assign link.trip_override = ovr_q;

endmodule

// ===== verification/spc_link_properties.sv
/*
 * Link checker: reset levels, command following, trip hold, override.
 * Assumes OVR_PERIOD equals the device's and one shared ref_clk.
 */
`timescale 1ns/10ps

module spc_link_properties #(
    parameter int OVR_PERIOD = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic on_cmd,
    input wire logic trip_override,
    input wire logic load_flag,
    input wire logic switch_flag
);
    // Slack covers two sync flops and the state register
    localparam int OVR_WAIT = OVR_PERIOD + 8;
    logic [7:0] on_cnt_q = 8'h00;
    logic [7:0] off_cnt_q = 8'h00;
    logic [7:0] ovr_cnt_q = 8'h00;
    logic [7:0] quiet_q = 8'h00;

    // Saturating run length
    function automatic logic [7:0] run(logic [7:0] c, logic hit);
        return hit ? ((c == 8'hff) ? c : c + 8'h01) : 8'h00;
    endfunction

    // Run counters; left running through reset, which is harmless
    always_ff @(posedge ref_clk) begin
        on_cnt_q <= run(on_cnt_q, on_cmd);
        off_cnt_q <= run(off_cnt_q, !on_cmd);
        ovr_cnt_q <= run(ovr_cnt_q, on_cmd && trip_override);
        quiet_q <= run(quiet_q, !trip_override);
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    AST_RST_DEV: assert property (disable iff (1'b0)
        rst |=> load_flag && !switch_flag)
        else $error("device flags wrong after reset");
    AST_RST_HOST: assert property (disable iff (1'b0)
        rst |=> !on_cmd && !trip_override)
        else $error("host commands wrong after reset");
    AST_OFF_FOLLOW: assert property (
        $fell(on_cmd) ##1 (!on_cmd) [*4] |-> !switch_flag)
        else $error("switch still on after command low");
    AST_OFF_HOLD: assert property (
        off_cnt_q >= 8'h05 |-> !switch_flag)
        else $error("switch on while command low");
    AST_ON_CAUSE: assert property (
        $rose(switch_flag) |-> $past(on_cmd, 2))
        else $error("switch on without command");
    AST_ON_FOLLOW: assert property (
        (!on_cmd) [*4] ##1 on_cmd |-> ##[2:5] switch_flag)
        else $error("switch did not follow command high");
    AST_OVR_RESTORE: assert property (
        ovr_cnt_q >= 8'(OVR_WAIT) |-> switch_flag)
        else $error("switch off during override");
    AST_TRIP_HOLD: assert property (
        $fell(switch_flag) && on_cnt_q >= 8'h06 &&
        quiet_q >= 8'(OVR_WAIT) ##1 (on_cmd && !trip_override) [*8]
        |-> !switch_flag)
        else $error("trip not held");

    cover property ($fell(switch_flag) && on_cmd);
    cover property (ovr_cnt_q == 8'(OVR_WAIT));
    cover property ($rose(on_cmd) ##[1:8] switch_flag);
endmodule

// ===== verification/power_switch_trip_control_tb.sv
/*
 * Bench: host and device ends on one link; the load draws current only
 * while the switch conducts. Assumes shortened OVR_PERIOD and SETTLE.
 */
`timescale 1ns/10ps

module power_switch_trip_control_tb;
    localparam int OVR = 16;
    localparam int SET = 20;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wdt_osc = 1'b0;
    logic fw_kick = 1'b1;
    logic cur_valid = 1'b1;
    logic on_req = 1'b0;
    logic override_req = 1'b0;
    logic [11:0] load_lvl = 12'h000;
    logic [11:0] cur_sample;
    logic [7:0] st;
    logic switch_gate, wdt_fired, st_settled;
    logic st_off_ok, st_on_load, st_on_idle, st_tripped, st_fault;
    int n_mismatch = 0;
    int check_count = 0;
    int n_fire = 0;
    int n_fault = 0;
    int n;

    // No current while off, so a tripped switch reads idle
    assign cur_sample = switch_gate ? load_lvl : 12'h000;
    assign st = {2'h0, st_settled, st_off_ok, st_on_load, st_on_idle,
        st_tripped, st_fault};

    spc_link_if link();
    spc_dev #(.OVR_PERIOD(OVR)) i_spc_dev(.ref_clk(ref_clk), .rst(rst),
        .link(link), .cur_sample(cur_sample), .cur_valid(cur_valid),
        .wdt_osc(wdt_osc), .fw_kick(fw_kick), .switch_gate(switch_gate),
        .wdt_fired(wdt_fired));
    spc_host #(.SETTLE(SET)) i_spc_host(.ref_clk(ref_clk), .rst(rst),
        .link(link), .on_req(on_req), .override_req(override_req),
        .st_settled(st_settled), .st_off_ok(st_off_ok),
        .st_on_load(st_on_load), .st_on_idle(st_on_idle),
        .st_tripped(st_tripped), .st_fault(st_fault));
    spc_link_properties #(.OVR_PERIOD(OVR)) i_spc_link_properties(
        .ref_clk(ref_clk), .rst(rst), .on_cmd(link.on_cmd),
        .trip_override(link.trip_override), .load_flag(link.load_flag),
        .switch_flag(link.switch_flag));

    // Main clock and an unrelated, slower watchdog oscillator
    initial forever #12.5 ref_clk = ~ref_clk;
    initial forever #35 wdt_osc = ~wdt_osc;
    always @(posedge ref_clk) if (wdt_fired === 1'b1) n_fire++;
    // A healthy device never earns a fault report from the host
    always @(posedge ref_clk) if (st_fault === 1'b1) n_fault++;

    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, hi, v);
        check_count++;
        if (v < lo || v > hi) begin
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, v);
            n_mismatch++;
        end
    endtask
    // Bounded wait for the gate level; n returns the cycles taken
    task automatic wait_gate(input logic v, input int lim);
        n = 0;
        while (switch_gate !== v && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic cmd(input logic v, input int c);
        on_req = v;
        tick(c);
    endtask

    task automatic t_basic();
        chk("gate", 8'h00, switch_gate);
        cmd(1'b0, SET + 20);
        chk("status", 8'h30, st);
        cmd(1'b1, 0);
        wait_gate(1'b1, 10);
        chk_rng("turn on", 3, 7, n);
        chk("switch flag", 8'h01, link.switch_flag);
        tick(SET + 20);
        chk("status", 8'h24, st);
        load_lvl = 12'h119;
        tick(3000);
        chk("gate", 8'h01, switch_gate);
        chk("load flag", 8'h00, link.load_flag);
        chk("status", 8'h28, st);
        $display("test basic done");
    endtask

    // Hot trip after steady 110 %, then cold trip after cooling
    task automatic t_thermal();
        load_lvl = 12'h258;
        wait_gate(1'b0, 500);
        chk_rng("hot trip", 8, 24, n);
        tick(SET + 10);
        chk("status", 8'h22, st);
        cmd(1'b0, 4200);
        chk("status", 8'h30, st);
        cmd(1'b1, 0);
        wait_gate(1'b1, 10);
        wait_gate(1'b0, 500);
        chk_rng("cold trip", 65, 95, n);
        $display("test thermal done");
    endtask

    task automatic t_instant();
        cmd(1'b0, 4200);
        load_lvl = 12'h834;
        cmd(1'b1, 0);
        wait_gate(1'b1, 10);
        wait_gate(1'b0, 6);
        chk_rng("instant trip", 1, 3, n);
        cmd(1'b0, SET + 20);
        cmd(1'b1, 0);
        wait_gate(1'b1, 10);
        chk("gate", 8'h01, switch_gate);
        wait_gate(1'b0, 6);
        chk_rng("retrip", 1, 3, n);
        cmd(1'b0, 40);
        load_lvl = 12'h6a4;
        cmd(1'b1, 0);
        wait_gate(1'b1, 10);
        tick(3);
        chk("gate", 8'h01, switch_gate);
        wait_gate(1'b0, 100);
        tick(40);
        chk("status", 8'h22, st);
        $display("test instant done");
    endtask

    task automatic t_override();
        load_lvl = 12'h834;
        override_req = 1'b1;
        wait_gate(1'b1, OVR + 10);
        chk("gate", 8'h01, switch_gate);
        tick(60);
        chk("gate", 8'h01, switch_gate);
        override_req = 1'b0;
        wait_gate(1'b0, OVR + 10);
        chk("gate", 8'h00, switch_gate);
        tick(40);
        chk("gate", 8'h00, switch_gate);
        $display("test override done");
    endtask

    // Watchdog reset forgets the trip and follows the command level
    task automatic t_wdt_power();
        load_lvl = 12'h000;
        chk("fired", 8'h00, 8'(n_fire));
        fw_kick = 1'b0;
        n = 0;
        while (wdt_fired !== 1'b1 && n < 4000) begin
            tick(1);
            n++;
        end
        chk_rng("watchdog", 2700, 2900, n);
        fw_kick = 1'b1;
        wait_gate(1'b1, 8);
        chk("gate", 8'h01, switch_gate);
        chk("fired", 8'h01, 8'(n_fire));
        rst = 1'b1;
        tick(1);
        chk("gate", 8'h00, switch_gate);
        tick(2);
        rst = 1'b0;
        wait_gate(1'b1, 12);
        chk("gate", 8'h01, switch_gate);
        chk("faults", 8'h00, 8'(n_fault));
        $display("test watchdog and power done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Guard well beyond the roughly 15000 cycles the tests need
    initial begin
        #(25.0 * 80000);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        tick(3);
        rst = 1'b0;
        t_basic();
        t_thermal();
        t_instant();
        t_override();
        t_wdt_power();
        end_of_test();
    end
endmodule
